//--- rtl/bfc_consts.svh
`ifndef BFC_CONSTS_SVH
`define BFC_CONSTS_SVH

// array geometry: 524,288 bytes, byte-wide data
`define BFC_ADDR_W 19
`define BFC_DATA_W 8
`define BFC_SECTOR_COUNT 11
`define BFC_ERASED_BYTE 8'hff

// status bit positions within a read byte
`define BFC_DATA_POLL_STATUS_BIT 7
`define BFC_TOGGLE_STATUS_BIT 6

// unlock addresses and command codes
`define BFC_UNLOCK1_ADDR 19'h00555
`define BFC_UNLOCK2_ADDR 19'h002aa
`define BFC_UNLOCK1_DATA 8'haa
`define BFC_UNLOCK2_DATA 8'h55
`define BFC_CMD_PROG 8'ha0
`define BFC_CMD_ERASE_SETUP 8'h80
`define BFC_CMD_SECTOR_ERASE 8'h30
`define BFC_CMD_CHIP_ERASE 8'h10
`define BFC_CMD_BYPASS_ON 8'h20
`define BFC_CMD_BYPASS_OFF1 8'h90
`define BFC_CMD_BYPASS_OFF2 8'h00
`define BFC_CMD_SUSPEND 8'hb0
`define BFC_CMD_RESUME 8'h30

// timing: clock period and pin times in ns, counts derived
`define BFC_CLK_NS 100
`define BFC_ACC_NS 70
`define BFC_ACC_CYC ((`BFC_ACC_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS)
`define BFC_WP_NS 35
`define BFC_WP_CYC ((`BFC_WP_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS)
`define BFC_RP_NS 500
`define BFC_RP_CYC ((`BFC_RP_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS)
`define BFC_BUSY_NS 90
`define BFC_BUSY_CYC (((`BFC_BUSY_NS / `BFC_CLK_NS) < 1) ? 1 : (`BFC_BUSY_NS / `BFC_CLK_NS))
`define BFC_SYNC_CYC 2
`define BFC_CNT_W 4

`endif

//--- rtl/bfc_pkg.sv
package bfc_pkg;
  typedef logic [18:0] bfc_addr_t;
  typedef logic [7:0] bfc_data_t;

  typedef enum logic [3:0] {
    OP_READ, OP_PROG, OP_SECT_ERASE, OP_CHIP_ERASE, OP_SUSPEND,
    OP_RESUME, OP_BYPASS_ON, OP_BYPASS_OFF, OP_RESET
  } bfc_op_e;

  typedef struct packed {
    bfc_addr_t addr;
    bfc_data_t data;
    logic last;
  } bfc_step_s;
endpackage

//--- rtl/bfc_cyc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bfc_cyc_if;
  import bfc_pkg::*;
  logic req;
  logic wr;
  bfc_addr_t addr;
  bfc_data_t wdata;
  logic done;
  bfc_data_t rdata;
  modport seq (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

//--- rtl/bfc_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
`include "bfc_consts.svh"
module bfc_bus_cycle (
  input wire logic clock,
  input wire logic rst_n,
  bfc_cyc_if.eng cyc,
  output logic [18:0] flashAddr,
  input wire logic [7:0] flashDqIn,
  output logic [7:0] flashDqOut,
  output logic flashDqOe,
  output logic flashCeN,
  output logic flashWeN,
  output logic flashOeN
);
  import bfc_pkg::*;
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_PULSE, E_RECOV} bfc_eng_e;

  bfc_eng_e st_q, st_d;
  logic [`BFC_CNT_W-1:0] cnt_q, cnt_d;
  logic wr_q, wr_d, ceN_q, ceN_d, weN_q, weN_d, oeN_q, oeN_d, dqOe_q, dqOe_d, done_q, done_d;
  bfc_addr_t addr_q, addr_d;
  bfc_data_t wdata_q, wdata_d, rdata_q, rdata_d, dqMeta_q, dqSync_q;

  // one bus cycle: setup, strobe pulse, recovery; strobes idle high
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    ceN_d = ceN_q;
    weN_d = weN_q;
    oeN_d = oeN_q;
    dqOe_d = dqOe_q;
    done_d = 1'b0;
    rdata_d = rdata_q;
    unique case (st_q)
      E_IDLE: if (cyc.req) begin
        st_d = E_SETUP;
        wr_d = cyc.wr;
        addr_d = cyc.addr;
        wdata_d = cyc.wdata;
        ceN_d = 1'b0;
        dqOe_d = cyc.wr; // drive dq only on writes, avoids contention
      end
      E_SETUP: begin
        st_d = E_PULSE;
        if (wr_q) begin
          weN_d = 1'b0;
          cnt_d = `BFC_CNT_W'(`BFC_WP_CYC);
        end else begin
          oeN_d = 1'b0;
          cnt_d = `BFC_CNT_W'(`BFC_ACC_CYC + `BFC_SYNC_CYC);
        end
      end
      E_PULSE: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == `BFC_CNT_W'(1)) begin
          st_d = E_RECOV;
          weN_d = 1'b1; // device latches addr and data on this rising edge
          oeN_d = 1'b1;
          if (!wr_q) rdata_d = dqSync_q;
        end
      end
      E_RECOV: begin
        st_d = E_IDLE;
        ceN_d = 1'b1; // back to standby between cycles
        dqOe_d = 1'b0;
        done_d = 1'b1;
      end
    endcase
  end

  // register the cycle state and sync the data pins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= E_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
      ceN_q <= 1'b1;
      weN_q <= 1'b1; // no write strobe while held in reset
      oeN_q <= 1'b1;
      dqOe_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= '0;
      dqMeta_q <= '0;
      dqSync_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      ceN_q <= ceN_d;
      weN_q <= weN_d;
      oeN_q <= oeN_d;
      dqOe_q <= dqOe_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
      dqMeta_q <= flashDqIn;
      dqSync_q <= dqMeta_q;
    end
  end

  // address held stable while idle so the device may sleep
  assign flashAddr = addr_q;
  assign flashDqOut = wdata_q;
  assign flashDqOe = dqOe_q;
  assign flashCeN = ceN_q;
  assign flashWeN = weN_q;
  assign flashOeN = oeN_q;
  assign cyc.done = done_q;
  assign cyc.rdata = rdata_q;
endmodule // bfc_bus_cycle
`default_nettype wire

//--- rtl/bfc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "bfc_consts.svh"
module bfc_host (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire bfc_pkg::bfc_op_e cmdOp,
  input wire bfc_pkg::bfc_addr_t cmdAddr,
  input wire bfc_pkg::bfc_data_t cmdData,
  output logic rspValid,
  output bfc_pkg::bfc_data_t rspData,
  output logic rspErr,
  output logic bypassOn,
  output logic eraseSuspended,
  output logic busy,
  output logic [18:0] flashAddr,
  input wire logic [7:0] flashDqIn,
  output logic [7:0] flashDqOut,
  output logic flashDqOe,
  output logic flashCeN,
  output logic flashWeN,
  output logic flashOeN,
  output logic flashResetN,
  input wire logic opDoneFlagN
);
  import bfc_pkg::*;
  typedef enum logic [2:0] {S_IDLE, S_WRITE, S_WAIT, S_POLL_A, S_POLL_B, S_READ, S_RESET} bfc_state_e;

  // steps of each unlock sequence; bypass programs skip the unlock pair
  function automatic bfc_step_s seqStep(bfc_op_e op, logic [2:0] n, logic byp, bfc_addr_t a, bfc_data_t d);
    bfc_step_s s;
    s.last = 1'b0;
    unique case (n % 3'd3)
      3'd0: s.addr = `BFC_UNLOCK1_ADDR;
      3'd1: s.addr = `BFC_UNLOCK2_ADDR;
      default: s.addr = `BFC_UNLOCK1_ADDR;
    endcase
    s.data = (n % 3'd3 == 3'd1) ? `BFC_UNLOCK2_DATA : `BFC_UNLOCK1_DATA;
    unique case (op)
      OP_PROG: if (byp) begin
        if (n == 3'd0) s.data = `BFC_CMD_PROG;
        else begin s.addr = a; s.data = d; s.last = 1'b1; end
      end else begin
        if (n == 3'd2) s.data = `BFC_CMD_PROG;
        if (n == 3'd3) begin s.addr = a; s.data = d; s.last = 1'b1; end
      end
      OP_SECT_ERASE: begin
        if (n == 3'd2) s.data = `BFC_CMD_ERASE_SETUP;
        if (n == 3'd5) begin s.addr = a; s.data = `BFC_CMD_SECTOR_ERASE; s.last = 1'b1; end
      end
      OP_CHIP_ERASE: begin
        if (n == 3'd2) s.data = `BFC_CMD_ERASE_SETUP;
        if (n == 3'd5) begin s.data = `BFC_CMD_CHIP_ERASE; s.last = 1'b1; end
      end
      OP_BYPASS_ON: if (n == 3'd2) begin s.data = `BFC_CMD_BYPASS_ON; s.last = 1'b1; end
      OP_BYPASS_OFF: begin
        s.data = (n == 3'd0) ? `BFC_CMD_BYPASS_OFF1 : `BFC_CMD_BYPASS_OFF2;
        s.last = (n != 3'd0);
      end
      OP_SUSPEND: begin s.addr = a; s.data = `BFC_CMD_SUSPEND; s.last = 1'b1; end
      OP_RESUME: begin s.addr = a; s.data = `BFC_CMD_RESUME; s.last = 1'b1; end
      default: s.last = 1'b1;
    endcase
    return s;
  endfunction

  function automatic logic isErase(bfc_op_e op);
    return (op == OP_SECT_ERASE) || (op == OP_CHIP_ERASE);
  endfunction

  bfc_cyc_if cyc ();

  bfc_state_e st_q, st_d;
  bfc_op_e op_q, op_d;
  bfc_addr_t addr_q, addr_d, eraseAddr_q, eraseAddr_d;
  bfc_data_t data_q, data_d, rspData_q, rspData_d;
  bfc_op_e eraseOp_q, eraseOp_d;
  logic [2:0] step_q, step_d;
  logic [`BFC_CNT_W-1:0] cnt_q, cnt_d;
  logic inFlight_q, inFlight_d, tog_q, tog_d, byp_q, byp_d, susp_q, susp_d, erasing_q, erasing_d;
  logic rspValid_q, rspValid_d, rspErr_q, rspErr_d, resetN_q, resetN_d;
  logic rdyMeta_q, rdySync_q, takeCmd, takeSusp, refuse;
  bfc_step_s step;

  // accept rules: idle, or an erase suspend between status polls
  always_comb begin
    takeSusp = (st_q == S_POLL_A) && !inFlight_q && cmdValid && (cmdOp == OP_SUSPEND) && isErase(op_q);
    cmdReady = (st_q == S_IDLE) || takeSusp;
    takeCmd = (st_q == S_IDLE) && cmdValid;
    refuse = (isErase(cmdOp) && erasing_q) || ((cmdOp == OP_RESUME) != susp_q && cmdOp == OP_RESUME)
      || (cmdOp == OP_SUSPEND) || (cmdOp == OP_PROG && susp_q && byp_q);
    step = seqStep(op_q, step_q, byp_q, addr_q, data_q);
    cyc.req = (st_q inside {S_WRITE, S_POLL_A, S_POLL_B, S_READ}) && !inFlight_q && !takeSusp;
    cyc.wr = (st_q == S_WRITE);
    cyc.addr = (st_q == S_WRITE) ? step.addr : addr_q;
    cyc.wdata = step.data;
  end

  // command sequencer: unlock writes, busy wait, toggle polling
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    addr_d = addr_q;
    data_d = data_q;
    eraseAddr_d = eraseAddr_q;
    eraseOp_d = eraseOp_q;
    step_d = step_q;
    cnt_d = cnt_q;
    inFlight_d = inFlight_q;
    tog_d = tog_q;
    byp_d = byp_q;
    susp_d = susp_q;
    erasing_d = erasing_q;
    rspValid_d = 1'b0;
    rspData_d = rspData_q;
    rspErr_d = rspErr_q;
    resetN_d = 1'b1;
    if (cyc.req) inFlight_d = 1'b1;
    if (cyc.done) inFlight_d = 1'b0;
    unique case (st_q)
      S_IDLE: if (takeCmd) begin
        op_d = cmdOp;
        addr_d = cmdAddr;
        data_d = cmdData;
        step_d = 3'd0;
        if (cmdOp == OP_RESET) begin
          st_d = S_RESET;
          resetN_d = 1'b0;
          cnt_d = `BFC_CNT_W'(`BFC_RP_CYC);
        end else if (refuse) begin
          rspValid_d = 1'b1;
          rspErr_d = 1'b1;
        end else if (cmdOp == OP_READ) st_d = S_READ;
        else if (cmdOp == OP_RESUME) begin
          st_d = S_WRITE;
          addr_d = eraseAddr_q;
        end else st_d = S_WRITE;
        if (isErase(cmdOp) && !refuse) begin
          eraseAddr_d = cmdAddr; // any of the eleven sectors
          eraseOp_d = cmdOp;
        end
      end
      S_WRITE: if (cyc.done) begin
        step_d = step_q + 3'd1;
        if (step.last) begin
          st_d = S_WAIT;
          cnt_d = `BFC_CNT_W'(`BFC_BUSY_CYC + `BFC_SYNC_CYC + 1);
          if (op_q == OP_BYPASS_ON || op_q == OP_BYPASS_OFF) begin
            st_d = S_IDLE;
            byp_d = (op_q == OP_BYPASS_ON);
            rspValid_d = 1'b1;
            rspErr_d = 1'b0;
          end
          if (isErase(op_q)) erasing_d = 1'b1;
          if (op_q == OP_RESUME) begin
            susp_d = 1'b0;
            op_d = eraseOp_q;
          end
        end
      end
      S_WAIT: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == `BFC_CNT_W'(1)) st_d = S_POLL_A;
      end
      S_POLL_A: if (takeSusp) begin
        op_d = OP_SUSPEND;
        step_d = 3'd0;
        st_d = S_WRITE;
      end else if (cyc.done) begin
        tog_d = cyc.rdata[`BFC_TOGGLE_STATUS_BIT];
        st_d = S_POLL_B;
      end
      S_POLL_B: if (cyc.done) begin
        st_d = S_POLL_A;
        // toggle bit steady and ready pin high means the algorithm ended
        if (cyc.rdata[`BFC_TOGGLE_STATUS_BIT] == tog_q && rdySync_q) begin
          st_d = S_IDLE;
          rspValid_d = 1'b1;
          rspData_d = cyc.rdata;
          rspErr_d = 1'b0;
          if (op_q == OP_SUSPEND) susp_d = 1'b1;
          if (op_q == OP_PROG) rspErr_d = (cyc.rdata != data_q);
          if (isErase(op_q)) begin
            erasing_d = 1'b0;
            rspErr_d = (cyc.rdata != `BFC_ERASED_BYTE);
          end
        end
      end
      S_READ: if (cyc.done) begin
        st_d = S_IDLE;
        rspValid_d = 1'b1;
        rspData_d = cyc.rdata;
        rspErr_d = 1'b0;
      end
      S_RESET: begin
        cnt_d = cnt_q - 1'b1;
        resetN_d = (cnt_q == `BFC_CNT_W'(1));
        if (cnt_q == `BFC_CNT_W'(1)) begin
          st_d = S_IDLE;
          byp_d = 1'b0;
          susp_d = 1'b0;
          erasing_d = 1'b0;
          rspValid_d = 1'b1;
          rspErr_d = 1'b0;
        end
      end
    endcase
  end

  // sequencer registers and ready pin synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      op_q <= OP_READ;
      addr_q <= '0;
      data_q <= '0;
      eraseAddr_q <= '0;
      eraseOp_q <= OP_SECT_ERASE;
      step_q <= '0;
      cnt_q <= '0;
      inFlight_q <= 1'b0;
      tog_q <= 1'b0;
      byp_q <= 1'b0;
      susp_q <= 1'b0;
      erasing_q <= 1'b0;
      rspValid_q <= 1'b0;
      rspData_q <= '0;
      rspErr_q <= 1'b0;
      resetN_q <= 1'b1;
      rdyMeta_q <= 1'b0;
      rdySync_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      addr_q <= addr_d;
      data_q <= data_d;
      eraseAddr_q <= eraseAddr_d;
      eraseOp_q <= eraseOp_d;
      step_q <= step_d;
      cnt_q <= cnt_d;
      inFlight_q <= inFlight_d;
      tog_q <= tog_d;
      byp_q <= byp_d;
      susp_q <= susp_d;
      erasing_q <= erasing_d;
      rspValid_q <= rspValid_d;
      rspData_q <= rspData_d;
      rspErr_q <= rspErr_d;
      resetN_q <= resetN_d;
      rdyMeta_q <= opDoneFlagN;
      rdySync_q <= rdyMeta_q;
    end
  end

  bfc_bus_cycle u_cycle (
    .clock(clock),
    .rst_n(rst_n),
    .cyc(cyc),
    .flashAddr(flashAddr),
    .flashDqIn(flashDqIn),
    .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe),
    .flashCeN(flashCeN),
    .flashWeN(flashWeN),
    .flashOeN(flashOeN)
  );

  // user-side status
  assign rspValid = rspValid_q;
  assign rspData = rspData_q;
  assign rspErr = rspErr_q;
  assign bypassOn = byp_q;
  assign eraseSuspended = susp_q;
  assign busy = (st_q != S_IDLE) || erasing_q;
  assign flashResetN = resetN_q;
endmodule // bfc_host
`default_nettype wire

//--- sim/bfc_host_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bfc_host_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic rspValid,
  input wire logic eraseSuspended,
  input wire logic busy,
  input wire logic [18:0] flashAddr,
  input wire logic flashDqOe,
  input wire logic flashCeN,
  input wire logic flashWeN,
  input wire logic flashOeN,
  input wire logic flashResetN
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // read strobe and reset pulse shapes
  sequence s_rdLow;
    !flashOeN [*3] ##1 flashOeN;
  endsequence
  sequence s_rstLow;
    !flashResetN [*5] ##1 flashResetN;
  endsequence
  a_oe_gated: assert property (!flashOeN |-> !flashDqOe && !flashCeN) else $error("oe overlap");
  a_we_oe_apart: assert property (!(!flashWeN && !flashOeN)) else $error("we with oe");
  a_write_pulse: assert property ($fell(flashWeN) |-> (!flashCeN && flashDqOe) ##1 flashWeN)
    else $error("we");
  a_addr_held: assert property (!flashCeN && !$past(flashCeN) |-> $stable(flashAddr)) else $error("addr");
  a_read_strobe: assert property ($fell(flashOeN) |-> s_rdLow) else $error("oe pulse");
  a_reset_pulse: assert property ($fell(flashResetN) |-> s_rstLow) else $error("reset pulse");
  // a new command taken right after a response may answer at once
  a_rsp_single: assert property (rspValid && !cmdValid |=> !rspValid) else $error("rsp pulse");
  a_ready_back: assert property (rspValid |-> cmdReady) else $error("not ready");
  a_suspend_busy: assert property (eraseSuspended |-> busy) else $error("suspend idle");
endmodule // bfc_host_chk
bind bfc_host bfc_host_chk i_bfc_host_chk (.clock(clock), .rst_n(rst_n), .cmdValid(cmdValid), .cmdReady(cmdReady),
  .rspValid(rspValid), .eraseSuspended(eraseSuspended), .busy(busy), .flashAddr(flashAddr),
  .flashDqOe(flashDqOe), .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
  .flashResetN(flashResetN));
`default_nettype wire

//--- sim/bfc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module bfc_flash_model #(
  parameter logic [10:0] PROT_MASK = 11'h040
) (
  input wire logic [18:0] flashAddr,
  input wire logic [7:0] flashDqOut,
  output logic [7:0] flashDqIn,
  input wire logic flashCeN,
  input wire logic flashWeN,
  input wire logic flashOeN,
  input wire logic flashResetN,
  output logic opDoneFlagN
);
  logic [7:0] mem [int];
  logic [7:0] tgt = 8'hff;
  int step = 0, progLeft = 0, eraseLeft = 0;
  bit byp, offArm, armProg, susp, tog;
  // seven 64k sectors, then 32k, 8k, 8k, 16k at the top
  function automatic int sectOf(logic [18:0] a);
    if (a[18:16] != 3'h7) return int'(a[18:16]);
    return a[15] ? (a[14] ? 10 : (a[13] ? 9 : 8)) : 7;
  endfunction
  // erase one sector unless protected
  task automatic wipe(int s);
    int k [$];
    foreach (mem[a]) if (sectOf(19'(a)) == s && !PROT_MASK[s]) k.push_back(a);
    foreach (k[i]) mem.delete(k[i]);
    eraseLeft = 30;
  endtask
  assign opDoneFlagN = !(progLeft > 0 || (eraseLeft > 0 && !susp));
  // command decode on write strobe release
  always @(posedge flashWeN) if (flashCeN === 1'b0 && flashResetN === 1'b1) begin
    if (!opDoneFlagN) begin
      if (flashDqOut == 8'hb0 && progLeft == 0) susp = 1;
    end else if (armProg) begin
      armProg = 0;
      tgt = flashDqOut;
      progLeft = 2 + $urandom % 6;
      if (!PROT_MASK[sectOf(flashAddr)])
        mem[flashAddr] = (mem.exists(flashAddr) ? mem[flashAddr] : 8'hff) & flashDqOut;
    end else if (susp && flashDqOut == 8'h30) susp = 0;
    else if (byp) begin
      if (offArm && flashDqOut == 8'h00) byp = 0;
      offArm = flashDqOut == 8'h90;
      armProg = flashDqOut == 8'ha0;
    end else case (step)
      0: step = (flashAddr[10:0] == 11'h555 && flashDqOut == 8'haa) ? 1 : 0;
      1: step = (flashAddr[10:0] == 11'h2aa && flashDqOut == 8'h55) ? 2 : 0;
      2: begin
        step = flashDqOut == 8'h80 ? 3 : 0;
        armProg = flashDqOut == 8'ha0;
        byp = flashDqOut == 8'h20;
      end
      3: step = flashDqOut == 8'haa ? 4 : 0;
      4: step = flashDqOut == 8'h55 ? 5 : 0;
      default: begin
        step = 0;
        if (flashDqOut == 8'h10) for (int s = 0; s < 11; s++) wipe(s);
        else if (flashDqOut == 8'h30) wipe(sectOf(flashAddr));
      end
    endcase
  end
  // status while busy, array otherwise
  always @(negedge flashOeN) if (flashCeN === 1'b0) begin
    if (!opDoneFlagN) begin
      tog = !tog;
      flashDqIn = {~tgt[7], tog, 6'h00};
      if (progLeft > 0) progLeft--;
      else eraseLeft--;
    end else flashDqIn = mem.exists(flashAddr) ? mem[flashAddr] : 8'hff;
  end
  // released bus shows the inverted last byte
  always @(posedge flashOeN) flashDqIn = ~flashDqIn;
  // hardware reset aborts any operation
  always @(negedge flashResetN) begin
    step = 0;
    progLeft = 0;
    eraseLeft = 0;
    {byp, offArm, armProg, susp} = 4'h0;
  end
endmodule // bfc_flash_model
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import bfc_pkg::*;
  typedef struct {logic err; logic useData; bfc_data_t data;} bfc_exp_s;
  logic clock, rst_n, cmdValid, cmdReady, rspValid, rspErr, bypassOn, eraseSuspended, busy;
  logic flashDqOe, flashCeN, flashWeN, flashOeN, flashResetN, opDoneFlagN;
  logic [18:0] flashAddr;
  logic [7:0] flashDqIn, flashDqOut;
  bfc_op_e cmdOp;
  bfc_addr_t cmdAddr, a, keepA;
  bfc_data_t cmdData, rspData, keepD;
  bfc_exp_s expQ [$], e;
  int fails = 0, compares = 0, rspSeen = 0, weFalls = 0, w;
  bfc_host i_bfc_host (.clock(clock), .rst_n(rst_n), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
    .rspErr(rspErr), .bypassOn(bypassOn), .eraseSuspended(eraseSuspended), .busy(busy),
    .flashAddr(flashAddr), .flashDqIn(flashDqIn), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
    .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN), .flashResetN(flashResetN),
    .opDoneFlagN(opDoneFlagN));
  bfc_flash_model i_bfc_flash_model (.flashAddr(flashAddr), .flashDqOut(flashDqOut),
    .flashDqIn(flashDqIn), .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
    .flashResetN(flashResetN), .opDoneFlagN(opDoneFlagN));
  // clock, 100 ns period
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  always @(negedge flashWeN) weFalls++;
  // response watcher takes the oldest expectation
  always @(negedge clock) if (rspValid === 1'b1) begin
    rspSeen++;
    e = expQ.pop_front();
    `CHK("rspErr", e.err, rspErr)
    if (e.useData) `CHK("rspData", e.data, rspData)
  end
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one command: hold until taken, then await its response when wr is set
  task automatic cmd(bfc_op_e op, bfc_addr_t ad, bfc_data_t d, logic err, logic ud, bfc_data_t ex, bit wr = 1);
    int n, got;
    got = rspSeen;
    n = 0;
    if (wr) expQ.push_back('{err, ud, ex});
    @(negedge clock);
    cmdValid = 1;
    cmdOp = op;
    cmdAddr = ad;
    cmdData = d;
    do begin @(posedge clock); n++; end while (cmdReady !== 1'b1 && n < 5000);
    @(negedge clock);
    cmdValid = 0;
    while (wr && rspSeen == got && n < 5000) begin @(negedge clock); n++; end
    if (n >= 5000) begin fails++; conclude(); end
  endtask
  initial begin
    rst_n = 0;
    cmdValid = 0;
    cmdOp = OP_READ;
    cmdAddr = 0;
    cmdData = 0;
    void'($urandom(32'h51dc));
    repeat (12) @(negedge clock);
    rst_n = 1;
    cmd(OP_READ, 19'h01234, 0, 0, 1, 8'hff);
    // random programs, normal sequence of four writes
    for (int i = 0; i < 6; i++) begin
      a = {3'(i), 16'($urandom)};
      keepD = 8'($urandom);
      w = weFalls;
      cmd(OP_PROG, a, keepD, 0, 0, 0);
      `CHK("writes", 4, weFalls - w)
      cmd(OP_READ, a, 0, 0, 1, keepD);
      if (i == 0) keepA = a;
    end
    if (keepA != a) keepD = 8'hff;
    keepA = a;
    // bits only clear; protected sector refuses
    cmd(OP_PROG, 19'h20010, 8'h0f, 0, 0, 0);
    cmd(OP_PROG, 19'h20010, 8'hf3, 1, 0, 0);
    cmd(OP_READ, 19'h20010, 0, 0, 1, 8'h03);
    cmd(OP_PROG, 19'h60020, 8'h5a, 1, 0, 0);
    cmd(OP_READ, 19'h60020, 0, 0, 1, 8'hff);
    // bypass program takes two writes
    cmd(OP_BYPASS_ON, 0, 0, 0, 0, 0);
    `CHK("bypassOn", 1'b1, bypassOn)
    w = weFalls;
    cmd(OP_PROG, 19'h30040, 8'h81, 0, 0, 0);
    `CHK("writes", 2, weFalls - w)
    cmd(OP_BYPASS_OFF, 0, 0, 0, 0, 0);
    cmd(OP_READ, 19'h30040, 0, 0, 1, 8'h81);
    // reset pin leaves bypass mode
    cmd(OP_BYPASS_ON, 0, 0, 0, 0, 0);
    cmd(OP_RESET, 0, 0, 0, 0, 0);
    `CHK("bypassOn", 1'b0, bypassOn)
    cmd(OP_PROG, 19'h30041, 8'h42, 0, 0, 0);
    cmd(OP_READ, 19'h30041, 0, 0, 1, 8'h42);
    // refusals with no pin activity
    w = weFalls;
    cmd(OP_RESUME, 0, 0, 1, 0, 0);
    cmd(OP_SUSPEND, 0, 0, 1, 0, 0);
    `CHK("writes", 0, weFalls - w)
    // erase suspended, other sector used, then resumed
    cmd(OP_SECT_ERASE, 19'h20000, 0, 0, 0, 0, 0);
    cmd(OP_SUSPEND, 19'h20000, 0, 0, 0, 0);
    `CHK("eraseSuspended", 1'b1, eraseSuspended)
    `CHK("busy", 1'b1, busy)
    cmd(OP_READ, 19'h30040, 0, 0, 1, 8'h81);
    cmd(OP_PROG, 19'h40100, 8'h3c, 0, 0, 0);
    cmd(OP_SECT_ERASE, 19'h10000, 0, 1, 0, 0);
    cmd(OP_RESUME, 19'h20000, 0, 0, 0, 0);
    `CHK("eraseSuspended", 1'b0, eraseSuspended)
    cmd(OP_READ, 19'h20010, 0, 0, 1, 8'hff);
    cmd(OP_READ, 19'h40100, 0, 0, 1, 8'h3c);
    // chip erase clears everything unprotected
    cmd(OP_CHIP_ERASE, 0, 0, 0, 0, 0);
    cmd(OP_READ, keepA, 0, 0, 1, 8'hff);
    `CHK("busy", 1'b0, busy)
    `CHK("pending", 0, expQ.size())
    conclude();
  end
endmodule // tb_top
`default_nettype wire
